// ===== core/scrc_top.sv
// Decided for this implementation: the address map and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module scrc_top #(
    parameter int BUS_OUTS = 5,
    parameter int UNITS = 2
) (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // configuration pins
    input wire logic host_role_strap,
    input wire logic input_halve_strap,
    input wire logic [1:0] rcw_src_strap,
    input wire logic [31:0] reset_cfg_low_word,
    // reference clock pins
    input wire logic primary_osc_in,
    input wire logic agent_pci_clk_in,
    // clock outputs
    output logic bus_sync_clk_out,
    output logic [BUS_OUTS-1:0] bus_clk_outputs,
    output logic dram_bus_clk_p,
    output logic dram_bus_clk_n,
    output logic local_bus_clk_out,
    output logic [UNITS-1:0] unit_clk_en,
    // decoded settings
    output logic [4:0] sys_bus_mult,
    output logic [5:0] dram_int_mult,
    output logic [5:0] local_int_mult,
    output logic [3:0] core_ratio_x2,
    output logic [3:0] core_vco_div,
    output logic core_pll_bypass,
    output logic cfg_reserved,
    output logic cfg_loaded
);
    import scrc_pkg::*;

    localparam int NSYNC = 6;

    scrc_state_t state;
    logic [NSYNC-1:0] s1;
    logic [NSYNC-1:0] s2;
    logic [NSYNC-1:0] s3;
    logic [NSYNC-1:0] filt;
    logic [1:0] settle;
    logic [31:0] cfg_word;
    logic host_role;
    logic halve;
    logic ref_prev;
    logic ref_half;
    logic [BUS_OUTS-1:0] pci_clkout_enables;
    logic [3:0] local_divider_field;
    logic [3:0] local_div_eff;
    logic [4*UNITS-1:0] unit_ctrl;
    logic [31:0] status_word;
    logic [31:0] next_rdata;
    logic [3:0] sys_pll_mult;
    logic [6:0] cpu_pll_code;
    logic dram_ratio_bit;
    logic local_port_ratio_bit;
    logic ref_sel;
    logic [31:0] src_word;

    scrc_cfg_if dec_if ();

    initial
    begin
        if (BUS_OUTS < 1 || BUS_OUTS > 16)
        begin
            $error("scrc_top: BUS_OUTS must be 1 to 16");
        end
        if (UNITS < 1 || UNITS > 4)
        begin
            $error("scrc_top: UNITS must be 1 to 4");
        end
    end

    // pin synchronisers; a level counts once stages two and three agree
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
        end
        else
        begin
            s1 <= {rcw_src_strap, input_halve_strap, host_role_strap,
                   agent_pci_clk_in, primary_osc_in};
            s2 <= s1;
            s3 <= s2;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++)
        begin : g_filt
            always_ff @(posedge mclk)
            begin
                if (sys_rst)
                begin
                    filt[gi] <= 1'b0;
                end
                else if (s2[gi] == s3[gi])
                begin
                    filt[gi] <= s3[gi];
                end
            end
        end
    endgenerate

    // pick the configuration word source
    always_comb
    begin
        case (filt[5:4])
            RCW_SRC_PINS: src_word = reset_cfg_low_word;
            RCW_SRC_OPT1: src_word = RCW_OPT1;
            RCW_SRC_OPT2: src_word = RCW_OPT2;
            default: src_word = RCW_OPT3;
        endcase
    end

    // load sequence: let straps settle, then capture once
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            state <= SCRC_WAIT;
            settle <= '0;
        end
        else
        begin
            case (state)
                SCRC_WAIT:
                begin
                    settle <= settle + 2'h1;
                    if (settle == CFG_SETTLE)
                    begin
                        state <= SCRC_LOAD;
                    end
                end
                SCRC_LOAD: state <= SCRC_RUN;
                SCRC_RUN: state <= SCRC_RUN;
                default: state <= SCRC_WAIT;
            endcase
        end
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            cfg_word <= '0;
            host_role <= 1'b0;
            halve <= 1'b0;
            cfg_loaded <= 1'b0;
        end
        else if (state == SCRC_LOAD)
        begin
            cfg_word <= src_word;
            host_role <= filt[2];
            halve <= filt[3];
            cfg_loaded <= 1'b1;
        end
    end

    assign sys_pll_mult = cfg_word[RCW_SYS_PLL_MULT_LSB +: RCW_SYS_PLL_MULT_W];
    assign cpu_pll_code = cfg_word[RCW_CORE_LSB +: RCW_CORE_W];
    assign dram_ratio_bit = cfg_word[RCW_DRAM_BIT];
    assign local_port_ratio_bit = cfg_word[RCW_LOCAL_BIT];
    assign dec_if.code = cpu_pll_code;

    scrc_pll_decode u_dec (
        .cfg(dec_if)
    );

    // decoded settings settle two cycles after the load, then hold until the next reset
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            sys_bus_mult <= '0;
            dram_int_mult <= '0;
            local_int_mult <= '0;
            core_ratio_x2 <= '0;
            core_vco_div <= '0;
            core_pll_bypass <= 1'b0;
            cfg_reserved <= 1'b0;
        end
        else if (state == SCRC_RUN && !cfg_loaded)
        begin
            sys_bus_mult <= '0;
        end
        else if (state == SCRC_RUN)
        begin
            sys_bus_mult <= halve ? {1'b0, sys_pll_mult}
                                  : {sys_pll_mult, 1'b0};
            dram_int_mult <= dram_ratio_bit ? {sys_bus_mult, 1'b0}
                                            : {1'b0, sys_bus_mult};
            local_int_mult <= local_port_ratio_bit ? {sys_bus_mult, 1'b0}
                                                   : {1'b0, sys_bus_mult};
            core_ratio_x2 <= dec_if.ratio_x2;
            core_vco_div <= dec_if.vco_div;
            core_pll_bypass <= dec_if.bypass;
            cfg_reserved <= dec_if.reserved;
        end
    end

    // reference selection by role, optional halving
    assign ref_sel = host_role ? filt[0] : filt[1];

    always_ff @(posedge mclk)
    begin
        if (sys_rst || !cfg_loaded)
        begin
            ref_prev <= 1'b0;
            ref_half <= 1'b0;
        end
        else
        begin
            ref_prev <= ref_sel;
            if (ref_sel && !ref_prev)
            begin
                ref_half <= !ref_half;
            end
        end
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst || !cfg_loaded)
        begin
            bus_sync_clk_out <= 1'b0;
        end
        else
        begin
            bus_sync_clk_out <= halve ? ref_half : ref_sel;
        end
    end

    generate
        for (gi = 0; gi < BUS_OUTS; gi++)
        begin : g_bus_out
            always_ff @(posedge mclk)
            begin
                if (sys_rst || !cfg_loaded)
                begin
                    bus_clk_outputs[gi] <= 1'b0;
                end
                else
                begin
                    bus_clk_outputs[gi] <= pci_clkout_enables[gi] &&
                                           (halve ? ref_half : ref_sel);
                end
            end
        end
    endgenerate

    // dram bus clock is the internal clock halved, differential pair
    scrc_local_divider_field #(
        .W(4)
    ) u_dram_div (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .run(cfg_loaded),
        .div(DRAM_BUS_DIV),
        .clk_out(dram_bus_clk_p),
        .clk_out_n(dram_bus_clk_n)
    );

    // local divider values below two would stop the clock
    assign local_div_eff = (local_divider_field < LOCAL_DIV_MIN)
                           ? LOCAL_DIV_MIN : local_divider_field;

    scrc_local_divider_field #(
        .W(4)
    ) u_local_div (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .run(cfg_loaded),
        .div(local_div_eff),
        .clk_out(local_bus_clk_out),
        .clk_out_n()
    );

    // per-unit clock enables: ratio field plus one, stop bit on top
    generate
        for (gi = 0; gi < UNITS; gi++)
        begin : g_unit
            logic [2:0] ucnt;
            always_ff @(posedge mclk)
            begin
                if (sys_rst || !cfg_loaded || unit_ctrl[4*gi+3])
                begin
                    ucnt <= '0;
                    unit_clk_en[gi] <= 1'b0;
                end
                else if (ucnt >= unit_ctrl[4*gi +: 3])
                begin
                    ucnt <= '0;
                    unit_clk_en[gi] <= 1'b1;
                end
                else
                begin
                    ucnt <= ucnt + 3'h1;
                    unit_clk_en[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // software registers
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            pci_clkout_enables <= '0;
            local_divider_field <= LOCAL_DIV_RST;
            unit_ctrl <= {UNITS{1'b0, UNIT_RATIO_RST}};
        end
        else if (reg_wr)
        begin
            case (reg_addr)
                OFF_OUT_CLK_CTRL:
                    pci_clkout_enables <= reg_wdata[BUS_OUTS-1:0];
                OFF_LOCAL_RATIO:
                    local_divider_field <= reg_wdata[3:0];
                OFF_UNIT_CLK_CTRL:
                    unit_ctrl <= reg_wdata[4*UNITS-1:0];
                default:
                    local_divider_field <= local_divider_field;
            endcase
        end
    end

    always_comb
    begin
        status_word = '0;
        status_word[ST_RATIO_LSB +: 4] = core_ratio_x2;
        status_word[ST_VCO_LSB +: 4] = core_vco_div;
        status_word[ST_BYPASS] = core_pll_bypass;
        status_word[ST_RESERVED] = cfg_reserved;
        status_word[ST_HOST] = host_role;
        status_word[ST_LOADED] = cfg_loaded;
        status_word[ST_SYSMUL_LSB +: 5] = sys_bus_mult;
        status_word[ST_DRAMMUL_LSB +: 6] = dram_int_mult;
        status_word[ST_LOCMUL_LSB +: 5] = local_int_mult[4:0];
    end

    always_comb
    begin
        next_rdata = '0;
        if (reg_rd)
        begin
            case (reg_addr)
                OFF_OUT_CLK_CTRL:
                    next_rdata[BUS_OUTS-1:0] = pci_clkout_enables;
                OFF_LOCAL_RATIO: next_rdata[3:0] = local_divider_field;
                OFF_UNIT_CLK_CTRL: next_rdata[4*UNITS-1:0] = unit_ctrl;
                OFF_STATUS: next_rdata = status_word;
                OFF_CFG_WORD: next_rdata = cfg_word;
                default: next_rdata = '0;
            endcase
        end
    end

    // read data stands for exactly the cycle after the strobe
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            reg_rdata <= '0;
        end
        else
        begin
            reg_rdata <= next_rdata;
        end
    end
endmodule // scrc_top
`default_nettype wire

// ===== pkg/scrc_pkg.sv
package scrc_pkg;
    // register offsets (byte addresses)
    localparam logic [7:0] OFF_OUT_CLK_CTRL = 8'h00;
    localparam logic [7:0] OFF_LOCAL_RATIO = 8'h04;
    localparam logic [7:0] OFF_UNIT_CLK_CTRL = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0C;
    localparam logic [7:0] OFF_CFG_WORD = 8'h10;
    // reset configuration word low fields
    localparam int RCW_SYS_PLL_MULT_LSB = 24;
    localparam int RCW_SYS_PLL_MULT_W = 4;
    localparam int RCW_CORE_LSB = 16;
    localparam int RCW_CORE_W = 7;
    localparam int RCW_DRAM_BIT = 30;
    localparam int RCW_LOCAL_BIT = 31;
    // built-in reset configuration options, selected by the source strap
    localparam logic [31:0] RCW_OPT1 = 32'h0402_0000;
    localparam logic [31:0] RCW_OPT2 = 32'h4408_0000;
    localparam logic [31:0] RCW_OPT3 = 32'hC205_0000;
    localparam logic [1:0] RCW_SRC_PINS = 2'h0;
    localparam logic [1:0] RCW_SRC_OPT1 = 2'h1;
    localparam logic [1:0] RCW_SRC_OPT2 = 2'h2;
    // core pll code fields
    localparam logic [3:0] CORE_MUL_BYPASS = 4'h0;
    localparam logic [3:0] CORE_MUL_1 = 4'h1;
    localparam logic [3:0] CORE_MUL_2 = 4'h2;
    localparam logic [3:0] CORE_MUL_3 = 4'h3;
    localparam logic [1:0] VCO_SEL_2 = 2'h0;
    localparam logic [1:0] VCO_SEL_4 = 2'h1;
    localparam logic [1:0] VCO_SEL_8 = 2'h2;
    localparam logic [3:0] VCO_DIV_2 = 4'h2;
    localparam logic [3:0] VCO_DIV_4 = 4'h4;
    localparam logic [3:0] VCO_DIV_8 = 4'h8;
    // status register fields
    localparam int ST_RATIO_LSB = 0;
    localparam int ST_VCO_LSB = 4;
    localparam int ST_BYPASS = 8;
    localparam int ST_RESERVED = 9;
    localparam int ST_HOST = 10;
    localparam int ST_LOADED = 11;
    localparam int ST_SYSMUL_LSB = 16;
    localparam int ST_DRAMMUL_LSB = 21;
    localparam int ST_LOCMUL_LSB = 27;
    // reset values, divider floor and settle count
    localparam logic [3:0] LOCAL_DIV_RST = 4'h2;
    localparam logic [3:0] LOCAL_DIV_MIN = 4'h2;
    localparam logic [2:0] UNIT_RATIO_RST = 3'h1;
    localparam logic [1:0] CFG_SETTLE = 2'h3;
    // dram bus clock is the internal dram clock halved
    localparam logic [3:0] DRAM_BUS_DIV = 4'h2;

    typedef enum logic [2:0] {
        SCRC_WAIT = 3'b001,
        SCRC_LOAD = 3'b010,
        SCRC_RUN = 3'b100
    } scrc_state_t;
endpackage : scrc_pkg

// ===== pkg/scrc_cfg_if.sv
`timescale 1ns/1ps
`default_nettype none
interface scrc_cfg_if;
    logic [6:0] code;
    logic [3:0] ratio_x2;
    logic [3:0] vco_div;
    logic bypass;
    logic reserved;

    modport dec (
        input code,
        output ratio_x2,
        output vco_div,
        output bypass,
        output reserved
    );
    modport user (
        output code,
        input ratio_x2,
        input vco_div,
        input bypass,
        input reserved
    );
endinterface : scrc_cfg_if
`default_nettype wire

// ===== core/scrc_pll_decode.sv
`timescale 1ns/1ps
`default_nettype none
module scrc_pll_decode (
    scrc_cfg_if.dec cfg
);
    import scrc_pkg::*;

    logic [3:0] mul;
    logic [1:0] vsel;
    logic half;

    always_comb
    begin
        vsel = cfg.code[1:0];
        mul = cfg.code[5:2];
        half = cfg.code[6];
        cfg.ratio_x2 = 4'h0;
        cfg.vco_div = 4'h0;
        cfg.bypass = 1'b0;
        cfg.reserved = 1'b0;
        if (mul == CORE_MUL_BYPASS && !half)
        begin
            cfg.bypass = 1'b1;
            cfg.ratio_x2 = 4'h2;
        end
        else if (vsel == 2'h3)
        begin
            cfg.reserved = 1'b1;
        end
        else
        begin
            // ratio held as twice core:bus so that the half steps fit
            case (mul)
                CORE_MUL_1: cfg.ratio_x2 = half ? 4'h3 : 4'h2;
                CORE_MUL_2: cfg.ratio_x2 = half ? 4'h5 : 4'h4;
                CORE_MUL_3: cfg.ratio_x2 = half ? 4'h0 : 4'h6;
                default: cfg.ratio_x2 = 4'h0;
            endcase
            case (vsel)
                VCO_SEL_2: cfg.vco_div = VCO_DIV_2;
                VCO_SEL_4: cfg.vco_div = VCO_DIV_4;
                VCO_SEL_8: cfg.vco_div = VCO_DIV_8;
                default: cfg.vco_div = 4'h0;
            endcase
            cfg.reserved = (cfg.ratio_x2 == 4'h0);
            if (cfg.reserved)
            begin
                cfg.vco_div = 4'h0;
            end
        end
    end
endmodule // scrc_pll_decode
`default_nettype wire

// ===== core/scrc_local_divider_field.sv
`timescale 1ns/1ps
`default_nettype none
module scrc_local_divider_field #(
    parameter int W = 4
) (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // control
    input wire logic run,
    input wire logic [W-1:0] div,
    // divided clock
    output logic clk_out,
    output logic clk_out_n
);
    logic [W-1:0] cnt;

    initial
    begin
        if (W < 2)
        begin
            $error("scrc_local_divider_field: W must be at least 2");
        end
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst || !run || cnt >= div - W'(1))
        begin
            cnt <= '0;
        end
        else
        begin
            cnt <= cnt + W'(1);
        end
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst || !run)
        begin
            clk_out <= 1'b0;
            clk_out_n <= 1'b0;
        end
        else
        begin
            clk_out <= (cnt < (div >> 1));
            clk_out_n <= !(cnt < (div >> 1));
        end
    end
endmodule // scrc_local_divider_field
`default_nettype wire

// ===== dv/scrc_osc_model.sv
`timescale 1ns/1ps
`default_nettype none
module scrc_osc_model #(
    parameter int OSC_HALF_NS = 203,
    parameter int PCI_HALF_NS = 331
) (
    // reference clocks
    output logic osc_out,
    output logic pci_out
);
    logic osc = 1'b0;
    logic pci = 1'b0;
    // both sources run free, unrelated in phase to mclk and to each other
    always #(OSC_HALF_NS) osc = ~osc;
    always #(PCI_HALF_NS) pci = ~pci;
    assign osc_out = osc;
    assign pci_out = pci;
endmodule // scrc_osc_model
`default_nettype wire

// ===== dv/scrc_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
module scrc_top_sva #(
    parameter int BUS_OUTS = 5,
    parameter int UNITS = 2
) (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // register port
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    // clock outputs
    input wire logic bus_sync_clk_out,
    input wire logic [BUS_OUTS-1:0] bus_clk_outputs,
    input wire logic dram_bus_clk_p,
    input wire logic dram_bus_clk_n,
    // decoded settings
    input wire logic [4:0] sys_bus_mult,
    input wire logic [5:0] dram_int_mult,
    input wire logic [3:0] core_ratio_x2,
    input wire logic [3:0] core_vco_div,
    input wire logic core_pll_bypass,
    input wire logic cfg_reserved,
    input wire logic cfg_loaded
);
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);

    rd_idle_zero_a: assert property (
        !$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data not zero outside read cycle");
    load_delay_a: assert property ($fell(sys_rst) |->
        !cfg_loaded [*4] ##[1:4] cfg_loaded)
        else $error("configuration load out of time");
    cfg_hold_a: assert property (cfg_loaded |=> cfg_loaded)
        else $error("loaded flag dropped without reset");
    dec_stable_a: assert property (cfg_loaded &&
        $past(cfg_loaded, 3) |->
        $stable(core_ratio_x2) && $stable(core_vco_div) &&
        $stable(sys_bus_mult) && $stable(dram_int_mult))
        else $error("decoded settings changed after load");
    bypass_dec_a: assert property (core_pll_bypass |->
        core_ratio_x2 == 4'h2 && core_vco_div == 4'h0 && !cfg_reserved)
        else $error("bypass decode wrong");
    resv_dec_a: assert property (cfg_reserved |->
        core_ratio_x2 == 4'h0 && core_vco_div == 4'h0)
        else $error("reserved code not neutralised");
    vco_set_a: assert property (core_vco_div != 4'h0 |->
        core_vco_div inside {4'h2, 4'h4, 4'h8} &&
        core_ratio_x2 inside {[4'h2:4'h6]})
        else $error("ratio or divider outside decode");
    bus_gate_a: assert property (|bus_clk_outputs |->
        bus_sync_clk_out)
        else $error("bus clock output without sync clock");
    dram_pair_a: assert property ($past(cfg_loaded, 2) &&
        cfg_loaded |->
        dram_bus_clk_p != dram_bus_clk_n &&
        dram_bus_clk_p != $past(dram_bus_clk_p))
        else $error("dram bus clock pair not halved or not complementary");
    dram_mult_a: assert property (cfg_loaded &&
        $past(cfg_loaded, 3) |->
        dram_int_mult == {1'b0, sys_bus_mult} ||
        dram_int_mult == {sys_bus_mult, 1'b0})
        else $error("dram multiple not one or two times system");
endmodule // scrc_top_sva

bind scrc_top scrc_top_sva #(.BUS_OUTS(BUS_OUTS), .UNITS(UNITS)) u_sva (
    .mclk(mclk), .sys_rst(sys_rst), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .bus_sync_clk_out(bus_sync_clk_out), .bus_clk_outputs(bus_clk_outputs),
    .dram_bus_clk_p(dram_bus_clk_p), .dram_bus_clk_n(dram_bus_clk_n),
    .sys_bus_mult(sys_bus_mult), .dram_int_mult(dram_int_mult),
    .core_ratio_x2(core_ratio_x2), .core_vco_div(core_vco_div),
    .core_pll_bypass(core_pll_bypass), .cfg_reserved(cfg_reserved),
    .cfg_loaded(cfg_loaded));
`default_nettype wire

// ===== dv/test_scrc_top.sv
`timescale 1ns/1ps
`default_nettype none
module test_scrc_top;
    import scrc_pkg::*;
    localparam int NB = 5;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic host = 1'b1;
    logic halve = 1'b0;
    logic [1:0] src = 2'h0;
    logic [31:0] word = 32'h0;
    logic [31:0] reg_rdata, w;
    logic osc, pci, sync_o, loc_o, dp, byp, resv, loaded;
    logic [NB-1:0] bus_o;
    logic [1:0] uen;
    logic [4:0] smul;
    logic [5:0] dmul, lmul;
    logic [3:0] rx2, vdiv;
    int fails = 0;
    int cmp_count = 0;
    int c_ref, c_sync, c_loc, c_dram, c_u0, c_u1;
    int c_bus [NB];
    int divs [4] = '{0, 3, 8, 15};

    always #12.5 mclk = ~mclk;

    scrc_osc_model src_model (.osc_out(osc), .pci_out(pci));

    scrc_top #(.BUS_OUTS(NB), .UNITS(2)) dut (
        .mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .host_role_strap(host),
        .input_halve_strap(halve), .rcw_src_strap(src),
        .reset_cfg_low_word(word), .primary_osc_in(osc),
        .agent_pci_clk_in(pci), .bus_sync_clk_out(sync_o),
        .bus_clk_outputs(bus_o), .dram_bus_clk_p(dp), .dram_bus_clk_n(),
        .local_bus_clk_out(loc_o), .unit_clk_en(uen), .sys_bus_mult(smul),
        .dram_int_mult(dmul), .local_int_mult(lmul), .core_ratio_x2(rx2),
        .core_vco_div(vdiv), .core_pll_bypass(byp), .cfg_reserved(resv),
        .cfg_loaded(loaded));

    task automatic test_done();
        if (fails == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e, g);
        cmp_count++;
        if (g !== e)
        begin
            fails++;
            $display("mismatch %s exp %h got %h", n, e, g);
        end
    endtask

    task automatic chkc(input string n, input int e, g, t);
        cmp_count++;
        if (g < e - t || g > e + t)
        begin
            fails++;
            $display("mismatch %s exp %0d got %0d", n, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] e, string n);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        chk(n, e, reg_rdata);
    endtask

    task automatic boot(input logic h, hv, input logic [1:0] s,
        logic [31:0] v);
        int i;
        @(posedge mclk);
        sys_rst <= 1'b1;
        host <= h;
        halve <= hv;
        src <= s;
        word <= v;
        repeat (3) @(posedge mclk);
        sys_rst <= 1'b0;
        i = 0;
        // look after the edge so the flag is read once it has settled
        while (loaded !== 1'b1 && i < 20)
        begin
            @(posedge mclk);
            #1;
            i++;
        end
        if (loaded !== 1'b1)
        begin
            chk("cfg_loaded", 32'h1, {31'h0, loaded});
            test_done();
        end
        repeat (3) @(posedge mclk);
        #1;
    endtask

    // expected {divider, ratio x2} from a core code; zero means reserved
    function automatic logic [7:0] dec(input logic [6:0] c);
        if (c[5:2] == 4'h0 && !c[6])
            return 8'h02;
        if (c[1:0] == 2'h3 || c[5:2] > 4'h3 || c[5:2] == 4'h0)
            return 8'h00;
        if (c[5:2] == 4'h3 && c[6])
            return 8'h00;
        // legal codes here have bit 5 clear, so ratio x2 is {bits 4-2, bit 6}
        return {4'h2 << c[1:0], c[4:2], c[6]};
    endfunction

    task automatic expect_cfg(input logic [31:0] v, input logic h, hv);
        logic [7:0] e;
        logic [4:0] sm;
        logic [5:0] dm, lm;
        logic b;
        e = dec(v[RCW_CORE_LSB +: RCW_CORE_W]);
        b = v[21:18] == 4'h0 && !v[22];
        sm = {1'b0, v[RCW_SYS_PLL_MULT_LSB +: RCW_SYS_PLL_MULT_W]} << !hv;
        dm = {1'b0, sm} << v[RCW_DRAM_BIT];
        lm = {1'b0, sm} << v[RCW_LOCAL_BIT];
        chk("outs", {5'h0, lm, dm, sm, e, b, e == 8'h0},
            {5'h0, lmul, dmul, smul, vdiv, rx2, byp, resv});
        rchk(OFF_STATUS, {lm[4:0], dm, sm, 5'h1, h, e == 8'h0, b, e},
            "st");
        rchk(OFF_CFG_WORD, v, "cfgword");
    endtask

    task automatic meas(input int n);
        logic pr, ps, pl, pd;
        logic [NB-1:0] pb;
        {c_ref, c_sync, c_loc, c_dram, c_u0, c_u1} = '0;
        c_bus = '{default: 0};
        {pr, ps, pl, pd, pb} = '1;
        repeat (n)
        begin
            @(posedge mclk);
            #1;
            c_ref += (host ? osc : pci) && !pr;
            c_sync += sync_o && !ps;
            c_loc += loc_o && !pl;
            c_dram += dp && !pd;
            c_u0 += uen[0];
            c_u1 += uen[1];
            for (int i = 0; i < NB; i++)
                c_bus[i] += bus_o[i] && !pb[i];
            {pr, ps, pl, pd, pb} = {host ? osc : pci, sync_o, loc_o, dp, bus_o};
        end
    endtask

    initial
    begin
        // reserved codes go in on purpose; frequency limits are not modelled
        for (int k = 0; k < 40; k++)
        begin
            w = {1'(k % 3 == 0), 1'(k % 5 == 1), 2'h0, 4'(k % 15 + 1),
                1'b0, 1'(k / 4), 4'(k / 8), 2'(k), 16'h0};
            boot(1'(k % 7 < 4), 1'(k / 5), 2'h0, w);
            expect_cfg(w, host, halve);
        end
        @(posedge mclk);
        word <= ~w;
        host <= ~host;
        halve <= ~halve;
        src <= 2'h1;
        repeat (8) @(posedge mclk);
        // straps were inverted after load, so the old ones are the inverse
        expect_cfg(w, ~host, ~halve);
        for (int s = 1; s < 4; s++)
        begin
            boot(1'b1, 1'b0, 2'(s), 32'hFFFF_FFFF);
            w = s == 1 ? RCW_OPT1 : s == 2 ? RCW_OPT2 : RCW_OPT3;
            expect_cfg(w, 1'b1, 1'b0);
        end
        for (int j = 0; j < 4; j++)
        begin
            boot(1'(j / 2), 1'(j), 2'h0, 32'h0104_0000);
            rchk(OFF_OUT_CLK_CTRL, 32'h0, "occ");
            wr(OFF_OUT_CLK_CTRL, 32'h15);
            meas(400);
            chkc("sync", halve ? c_ref / 2 : c_ref, c_sync, 1);
            for (int i = 0; i < NB; i++)
                chkc("bus", i % 2 ? 0 : c_sync, c_bus[i],
                    i % 2 ? 0 : 1);
        end
        rchk(OFF_LOCAL_RATIO, {28'h0, LOCAL_DIV_RST}, "lcr");
        rchk(OFF_UNIT_CLK_CTRL, {25'h0, UNIT_RATIO_RST, 1'b0,
            UNIT_RATIO_RST}, "ucc");
        meas(120);
        chkc("dram", 60, c_dram, 1);
        chkc("local_bus_clk_out", 60, c_loc, 1);
        chkc("unit0", 60, c_u0, 1);
        chkc("unit1", 60, c_u1, 1);
        foreach (divs[i])
        begin
            wr(OFF_LOCAL_RATIO, divs[i]);
            meas(120);
            chkc("local_bus_clk_out", 120 / (divs[i] < 2 ? 2 : divs[i]),
                c_loc, 1);
        end
        wr(OFF_UNIT_CLK_CTRL, 32'h83);
        rchk(OFF_UNIT_CLK_CTRL, 32'h83, "ucc");
        meas(120);
        chkc("unit0", 30, c_u0, 1);
        chkc("unit1", 0, c_u1, 0);
        wr(OFF_UNIT_CLK_CTRL, 32'h0);
        meas(120);
        chkc("unit0", 120, c_u0, 1);
        wr(8'h14, 32'hFFFF_FFFF);
        rchk(8'h14, 32'h0, "unmapped");
        wr(OFF_STATUS, 32'h0);
        wr(OFF_CFG_WORD, 32'h0);
        expect_cfg(32'h0104_0000, 1'b1, 1'b1);
        test_done();
    end
endmodule // test_scrc_top
`default_nettype wire
